// ### hdl/cio_port.sv
// Clocked I/O port subsystem: five ports, six clock blocks, pin sharing, AXI4-Lite registers.
// Assumes pins and strobes are synchronous to clk_in; the scheduler takes event_out pulses.
`timescale 1ns/100ps
module cio_port import cio_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe_n_out,
  input wire logic [4:0] strobe_in,
  output logic [4:0] strobe_out,
  output logic [4:0] event_out,
  output logic irq_out
);
  // Port k owns pins 0..W-1; narrower ports come first so they win shared pins
  localparam int PW [`CIO_NPORT] = '{1, 4, 8, 16, 32};
  localparam logic [31:0] PMSK [`CIO_NPORT] = '{32'h0000_0001, 32'h0000_000f, 32'h0000_00ff,
                                                 32'h0000_ffff, 32'hffff_ffff};

  cio_state_t s_q;
  cio_state_t s_d;
  logic [4:0] ptick_d;
  logic [4:0] load_d;
  logic [4:0] rxdone_d;

  function automatic logic [31:0] cio_merge(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    logic pin0_rise;
    logic src;
    logic [7:0] div;
    logic [2:0] cb;
    logic tmatch;
    logic condok;
    logic stbok;
    logic found;
    logic [31:0] nw;
    logic [4:0] evset;
    logic [4:0] clr;
    logic [2:0] k;
    logic [2:0] idx;
    logic [2:0] b;
    logic [11:0] a;
    logic [31:0] rd;
    logic rd_ok;
    pin0_rise = 1'b0;
    src = 1'b0;
    div = 8'h00;
    cb = 3'h0;
    tmatch = 1'b0;
    condok = 1'b0;
    stbok = 1'b0;
    found = 1'b0;
    nw = 32'h0000_0000;
    evset = 5'h00;
    clr = 5'h00;
    k = 3'h0;
    idx = 3'h0;
    b = 3'h0;
    a = 12'h000;
    rd = 32'h0000_0000;
    rd_ok = 1'b0;
    s_d = s_q;
    ptick_d = 5'h00;
    load_d = 5'h00;
    rxdone_d = 5'h00;
    s_d.stb = 5'h00;
    s_d.evt = 5'h00;

    // Clock blocks: block 0 ticks on every reference edge
    pin0_rise = pin_in[0] & ~s_q.pin0_prev;
    s_d.pin0_prev = pin_in[0];
    s_d.cbtick[0] = 1'b1;
    for (int i = 1; i < `CIO_NCB; i++) begin
      src = s_q.cbcfg[i][`CIO_CB_SRC_PIN] ? pin0_rise : 1'b1;
      div = s_q.cbcfg[i][`CIO_CB_DIV_LSB +: 8];
      s_d.cbtick[i] = 1'b0;
      if (src) begin
        if (div == 8'h00 || s_q.cbdiv[i] == div - 8'h01) begin
          s_d.cbtick[i] = 1'b1;
          s_d.cbdiv[i] = 8'h00;
        end else begin
          s_d.cbdiv[i] = s_q.cbdiv[i] + 8'h01;
        end
      end
    end

    // Ports
    for (int p = 0; p < `CIO_NPORT; p++) begin
      cb = s_q.ctrl[p][`CIO_C_CB_LSB +: 3];
      ptick_d[p] = s_q.ctrl[p][`CIO_C_EN] && (cb < 3'd6) && s_q.cbtick[cb];
      tmatch = !s_q.ctrl[p][`CIO_C_TIMED] || (s_q.cnt[p] == s_q.tmr[p]);
      condok = !s_q.ctrl[p][`CIO_C_COND] || ((pin_in & PMSK[p]) == (s_q.cond[p] & PMSK[p]));
      stbok = !s_q.ctrl[p][`CIO_C_STBIN] || strobe_in[p];
      if (ptick_d[p]) begin
        s_d.cnt[p] = s_q.cnt[p] + 16'h0001;
        if (s_q.ctrl[p][`CIO_C_OUT]) begin
          // Output slices leave W bits per tick, low bits first
          if (s_q.pos[p] != 6'h00) begin
            s_d.pout[p] = s_q.shreg[p] & PMSK[p];
            s_d.shreg[p] = s_q.shreg[p] >> PW[p];
            s_d.pos[p] = s_q.pos[p] - 6'h01;
            s_d.stb[p] = s_q.ctrl[p][`CIO_C_STBOUT];
          end else if (s_q.full[p] && tmatch) begin
            load_d[p] = 1'b1;
            s_d.pout[p] = s_q.xfer[p] & PMSK[p];
            s_d.shreg[p] = s_q.xfer[p] >> PW[p];
            s_d.pos[p] = 6'(32 / PW[p] - 1);
            s_d.full[p] = 1'b0;
            s_d.tst[p] = s_q.cnt[p];
            s_d.stb[p] = s_q.ctrl[p][`CIO_C_STBOUT];
          end
        end else if (stbok && (s_q.pos[p] != 6'h00 || (tmatch && condok))) begin
          nw = (s_q.shreg[p] >> PW[p]) | ((pin_in & PMSK[p]) << (32 - PW[p]));
          s_d.shreg[p] = nw;
          if (s_q.pos[p] == 6'(32 / PW[p] - 1)) begin
            // Overrun overwrites the unread word; newest data wins
            rxdone_d[p] = 1'b1;
            s_d.xfer[p] = nw;
            s_d.full[p] = 1'b1;
            s_d.pos[p] = 6'h00;
            s_d.tst[p] = s_q.cnt[p];
          end else begin
            s_d.pos[p] = s_q.pos[p] + 6'h01;
          end
        end
      end
      s_d.evt[p] = load_d[p] | rxdone_d[p];
      evset[p] = load_d[p] | rxdone_d[p];
    end

    // Pin ownership: narrowest enabled port wins, link overrides all ports on pins 24 and up
    for (int n = 0; n < `CIO_NPIN; n++) begin
      found = 1'b0;
      s_d.pin_o[n] = 1'b0;
      s_d.pin_oen[n] = 1'b1;
      for (int p = 0; p < `CIO_NPORT; p++) begin
        if (!found && s_q.ctrl[p][`CIO_C_EN] && n < PW[p]) begin
          found = 1'b1;
          if (s_q.ctrl[p][`CIO_C_OUT]) begin
            if (s_q.ctrl[p][`CIO_C_OD]) begin
              s_d.pin_oen[n] = s_q.pout[p][n];
            end else begin
              s_d.pin_o[n] = s_q.pout[p][n];
              s_d.pin_oen[n] = 1'b0;
            end
          end
        end
      end
      if (s_q.link && n >= `CIO_LINK_LO) begin
        s_d.pin_o[n] = 1'b0;
        s_d.pin_oen[n] = 1'b1;
      end
    end

    // AXI4-Lite write: address and data in either order, answer next cycle
    if (s_axi_awvalid_in && s_q.awrdy) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_q.wrdy) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata_in;
      s_d.wstrb = s_axi_wstrb_in;
    end
    if (s_q.bvalid && s_axi_bready_in) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      a = s_q.awaddr;
      k = a[7:5];
      idx = a[4:2];
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `CIO_RESP_OKAY;
      if (a[11:8] == 4'h0 && k < 3'd5 && idx <= `CIO_IDX_COND) begin
        case (idx)
          `CIO_IDX_CTRL: begin
            s_d.ctrl[k] = 16'(cio_merge({16'h0000, s_q.ctrl[k]}, s_q.wdata, s_q.wstrb));
            s_d.pos[k] = 6'h00;
            s_d.full[k] = 1'b0;
          end
          `CIO_IDX_DATA: begin
            if (s_q.ctrl[k][`CIO_C_OUT]) begin
              s_d.xfer[k] = cio_merge(s_q.xfer[k], s_q.wdata, s_q.wstrb);
              s_d.full[k] = 1'b1;
            end
          end
          `CIO_IDX_TIME: s_d.tmr[k] = 16'(cio_merge({16'h0000, s_q.tmr[k]}, s_q.wdata, s_q.wstrb));
          `CIO_IDX_COND: s_d.cond[k] = cio_merge(s_q.cond[k], s_q.wdata, s_q.wstrb);
          default: begin
          end
        endcase
      end else if (a[11:2] == `CIO_OFF_STATUS >> 2) begin
        clr = s_q.wdata[4:0] & {5{s_q.wstrb[0]}};
      end else if (a[11:2] == `CIO_OFF_MASK >> 2) begin
        s_d.mask = s_q.wstrb[0] ? s_q.wdata[4:0] : s_q.mask;
      end else if (a[11:2] == `CIO_OFF_LINK >> 2) begin
        s_d.link = s_q.wstrb[0] ? s_q.wdata[0] : s_q.link;
      end else if (a >= `CIO_OFF_CB_BASE && a < `CIO_OFF_CB_BASE + 12'h018) begin
        b = 3'((a - `CIO_OFF_CB_BASE) >> 2);
        // Block 0 is the fixed reference and ignores writes
        if (b != 3'h0) begin
          s_d.cbcfg[b] = 16'(cio_merge({16'h0000, s_q.cbcfg[b]}, s_q.wdata, s_q.wstrb));
        end
      end else begin
        s_d.bresp = `CIO_RESP_SLVERR;
      end
    end
    // Set wins over a write-one clear landing in the same cycle
    s_d.stat = (s_q.stat & ~clr) | evset;
    s_d.irq = |(s_d.stat & s_d.mask);
    s_d.awrdy = !s_d.aw_got && !s_d.bvalid;
    s_d.wrdy = !s_d.w_got && !s_d.bvalid;

    // AXI4-Lite read: data registered on the same edge that takes the address
    if (s_q.rvalid && s_axi_rready_in) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_q.arrdy) begin
      a = s_axi_araddr_in;
      k = a[7:5];
      idx = a[4:2];
      rd_ok = 1'b1;
      if (a[11:8] == 4'h0 && k < 3'd5 && idx <= `CIO_IDX_COND) begin
        case (idx)
          `CIO_IDX_CTRL: rd = {16'h0000, s_q.ctrl[k]};
          `CIO_IDX_DATA: begin
            rd = s_q.xfer[k];
            if (!s_q.ctrl[k][`CIO_C_OUT] && !rxdone_d[k]) begin
              s_d.full[k] = 1'b0;
            end
          end
          `CIO_IDX_CNT: rd = {16'h0000, s_q.cnt[k]};
          `CIO_IDX_TIME: rd = {16'h0000, s_q.tmr[k]};
          `CIO_IDX_TSTAMP: rd = {16'h0000, s_q.tst[k]};
          `CIO_IDX_COND: rd = s_q.cond[k];
          default: rd_ok = 1'b0;
        endcase
      end else if (a[11:2] == `CIO_OFF_STATUS >> 2) begin
        rd = {27'h0, s_q.stat};
      end else if (a[11:2] == `CIO_OFF_MASK >> 2) begin
        rd = {27'h0, s_q.mask};
      end else if (a[11:2] == `CIO_OFF_LINK >> 2) begin
        rd = {31'h0, s_q.link};
      end else if (a >= `CIO_OFF_CB_BASE && a < `CIO_OFF_CB_BASE + 12'h018) begin
        b = 3'((a - `CIO_OFF_CB_BASE) >> 2);
        rd = {16'h0000, s_q.cbcfg[b]};
      end else begin
        rd_ok = 1'b0;
      end
      s_d.rvalid = 1'b1;
      s_d.rdata = rd;
      s_d.rresp = rd_ok ? `CIO_RESP_OKAY : `CIO_RESP_SLVERR;
    end
    s_d.arrdy = !s_d.rvalid;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
      s_q.ctrl <= {`CIO_NPORT{`CIO_CTRL_RST}};
      s_q.pin_oen <= '1;
      // Idle high, so a pulled-up pin shows no false rise after reset
      s_q.pin0_prev <= 1'b1;
      s_q.awrdy <= 1'b1;
      s_q.wrdy <= 1'b1;
      s_q.arrdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready_out = s_q.awrdy;
  assign s_axi_wready_out = s_q.wrdy;
  assign s_axi_bresp_out = s_q.bresp;
  assign s_axi_bvalid_out = s_q.bvalid;
  assign s_axi_arready_out = s_q.arrdy;
  assign s_axi_rdata_out = s_q.rdata;
  assign s_axi_rresp_out = s_q.rresp;
  assign s_axi_rvalid_out = s_q.rvalid;
  assign pin_out = s_q.pin_o;
  assign pin_oe_n_out = s_q.pin_oen;
  assign strobe_out = s_q.stb;
  assign event_out = s_q.evt;
  assign irq_out = s_q.irq;

  default clocking cio_cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_cnt_adv;
    ptick_d[1] |=> s_q.cnt[1] == $past(s_q.cnt[1]) + 16'h0001;
  endproperty
  a_cnt_adv: assert property (p_cnt_adv) else $error("port counter did not advance on tick");

  property p_cnt_hold;
    !ptick_d[2] |=> $stable(s_q.cnt[2]);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("port counter moved without tick");

  property p_tstamp;
    (load_d[3] || rxdone_d[3]) |=> s_q.tst[3] == $past(s_q.cnt[3]);
  endproperty
  a_tstamp: assert property (p_tstamp) else $error("timestamp not captured");

  property p_timed;
    (load_d[4] && s_q.ctrl[4][`CIO_C_TIMED]) |-> s_q.cnt[4] == s_q.tmr[4];
  endproperty
  a_timed: assert property (p_timed) else $error("timed transfer off its count");

  property p_link;
    s_q.link |=> &s_q.pin_oen[31:24];
  endproperty
  a_link: assert property (p_link) else $error("link pins still driven");

  property p_reset_cb;
    $past(!rst_n_in) |-> s_q.ctrl[0][`CIO_C_CB_LSB +: 3] == 3'h0 && s_q.ctrl[4][`CIO_C_CB_LSB +: 3] == 3'h0;
  endproperty
  a_reset_cb: assert property (@(posedge clk_in) p_reset_cb) else $error("port not on block 0");

  property p_read_one;
    (s_axi_arvalid_in && s_q.arrdy) |=> s_q.rvalid;
  endproperty
  a_read_one: assert property (p_read_one) else $error("read answer late");

  property p_event;
    rxdone_d[1] |=> event_out[1] && s_q.stat[1];
  endproperty
  a_event: assert property (p_event) else $error("event not delivered");

  property p_narrow;
    (s_q.ctrl[2][`CIO_C_EN] && !s_q.ctrl[3][`CIO_C_EN] && s_q.ctrl[4][`CIO_C_EN] && s_q.ctrl[4][`CIO_C_OUT]
      && !s_q.ctrl[4][`CIO_C_OD] && !s_q.link)
      |=> !s_q.pin_oen[8] && s_q.pin_o[8] == $past(s_q.pout[4][8]);
  endproperty
  a_narrow: assert property (p_narrow) else $error("wide port lost its unshared pin");

  property p_od;
    (s_q.ctrl[2][`CIO_C_EN] && s_q.ctrl[2][`CIO_C_OUT] && s_q.ctrl[2][`CIO_C_OD])
      |=> !s_q.pin_o[7] && s_q.pin_oen[7] == $past(s_q.pout[2][7]);
  endproperty
  a_od: assert property (p_od) else $error("open drain drove high");

  c_out_load: cover property (load_d[4] ##1 strobe_out[4]);
  c_in_word: cover property (rxdone_d[1] ##1 event_out[1]);
  c_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
endmodule

// ### hdl/cio_defs.svh
// Offsets, field positions and reset values of the clocked I/O port block.
// Assumes a single clock domain and an AXI4-Lite master on the register side.
`ifndef CIO_DEFS_SVH
`define CIO_DEFS_SVH
`define CIO_NPORT 5
`define CIO_NCB 6
`define CIO_NPIN 32
`define CIO_LINK_LO 24
// Port register word index inside a port window
`define CIO_IDX_CTRL 3'h0
`define CIO_IDX_DATA 3'h1
`define CIO_IDX_CNT 3'h2
`define CIO_IDX_TIME 3'h3
`define CIO_IDX_TSTAMP 3'h4
`define CIO_IDX_COND 3'h5
`define CIO_OFF_STATUS 12'h100
`define CIO_OFF_MASK 12'h104
`define CIO_OFF_LINK 12'h108
`define CIO_OFF_CB_BASE 12'h140
// Control and clock block config field positions
`define CIO_C_EN 0
`define CIO_C_OUT 1
`define CIO_C_OD 2
`define CIO_C_TIMED 3
`define CIO_C_COND 4
`define CIO_C_STBIN 5
`define CIO_C_STBOUT 6
`define CIO_C_CB_LSB 8
`define CIO_CB_SRC_PIN 0
`define CIO_CB_DIV_LSB 8
`define CIO_CTRL_RST 16'h0000
`define CIO_RESP_OKAY 2'b00
`define CIO_RESP_SLVERR 2'b10
`endif

// ### hdl/cio_pkg.sv
// Types shared by the clocked I/O port block.
// Assumes the constants header is on the include path.
`include "cio_defs.svh"
package cio_pkg;
  typedef struct packed {
    logic [`CIO_NPORT-1:0][15:0] ctrl;
    logic [`CIO_NPORT-1:0][31:0] xfer;
    logic [`CIO_NPORT-1:0][31:0] shreg;
    logic [`CIO_NPORT-1:0][31:0] pout;
    logic [`CIO_NPORT-1:0][5:0] pos;
    logic [`CIO_NPORT-1:0] full;
    logic [`CIO_NPORT-1:0][15:0] cnt;
    logic [`CIO_NPORT-1:0][15:0] tmr;
    logic [`CIO_NPORT-1:0][15:0] tst;
    logic [`CIO_NPORT-1:0][31:0] cond;
    logic [`CIO_NCB-1:0][15:0] cbcfg;
    logic [`CIO_NCB-1:0][7:0] cbdiv;
    logic [`CIO_NCB-1:0] cbtick;
    logic pin0_prev;
    logic [`CIO_NPORT-1:0] stat;
    logic [`CIO_NPORT-1:0] mask;
    logic link;
    logic [`CIO_NPIN-1:0] pin_o;
    logic [`CIO_NPIN-1:0] pin_oen;
    logic [`CIO_NPORT-1:0] stb;
    logic [`CIO_NPORT-1:0] evt;
    logic irq;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awrdy;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cio_state_t;
endpackage

// ### verification/cio_pin_partner.sv
// Board-side model of the pins and input strobes of the clocked I/O port block.
// Assumes a pull-up on every pin and a driver synchronous to clk_in.
`timescale 1ns/100ps
module cio_pin_partner (
  input wire logic clk_in,
  input wire logic [31:0] pin_out_in,
  input wire logic [31:0] pin_oe_n_in,
  output logic [31:0] pin_in_out,
  output logic [4:0] strobe_in_out
);
  logic [31:0] drv_en_q = '0;
  logic [31:0] drv_val_q = '0;
  initial strobe_in_out = '0;
  // Released lines float to the pull-up level
  always_comb begin
    for (int n = 0; n < 32; n++) begin
      if (drv_en_q[n]) begin
        pin_in_out[n] = drv_val_q[n];
      end else if (!pin_oe_n_in[n]) begin
        pin_in_out[n] = pin_out_in[n];
      end else begin
        pin_in_out[n] = 1'b1;
      end
    end
  end
  // Data held a cycle either side of the strobe, so a skew of one cycle is harmless
  task automatic send_word(input int w, input int port, input logic [31:0] word);
    int i;
    logic [31:0] m;
    m = (32'h1 << w) - 1;
    for (i = 0; i < 32 / w; i++) begin
      @(posedge clk_in);
      drv_en_q <= m;
      drv_val_q <= (word >> (i * w)) & m;
      @(posedge clk_in);
      strobe_in_out <= 5'h01 << port;
      @(posedge clk_in);
      strobe_in_out <= '0;
      @(posedge clk_in);
    end
    @(posedge clk_in);
    drv_en_q <= '0;
  endtask
  // Starts and ends high, so releasing to the pull-up adds no edge
  task automatic clock_pin0(input int n);
    int i;
    @(posedge clk_in);
    drv_en_q[0] <= 1'b1;
    drv_val_q[0] <= 1'b1;
    for (i = 0; i < n; i++) begin
      repeat (2) @(posedge clk_in);
      drv_val_q[0] <= 1'b0;
      repeat (2) @(posedge clk_in);
      drv_val_q[0] <= 1'b1;
    end
    repeat (2) @(posedge clk_in);
    drv_en_q[0] <= 1'b0;
  endtask
endmodule

// ### verification/tb_cio_port.sv
// Self-checking bench for the clocked I/O port block.
// Assumes the pin partner model and the constants header are available.
`timescale 1ns/100ps
`include "cio_defs.svh"
module tb_cio_port;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, pin_in, pin_out, oe_n;
  wire [4:0] stb_in, stb_out, evt;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int sc = 0;
  int ec = 0;
  logic [31:0] d4 = 32'ha5c33c5a;

  initial forever #4 clk_in = ~clk_in;

  cio_port i_cio_port (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(oe_n), .strobe_in(stb_in),
    .strobe_out(stb_out), .event_out(evt), .irq_out(irq));
  cio_pin_partner i_cio_pin_partner (.clk_in(clk_in), .pin_out_in(pin_out), .pin_oe_n_in(oe_n),
    .pin_in_out(pin_in), .strobe_in_out(stb_in));

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    sc <= sc + stb_out[4];
    ec <= ec + evt[4];
    if (cyc == 8000) begin
      error_cnt++;
      tally_and_finish;
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [11:0] pa(input int k, input int idx);
    return 12'(k * 32 + idx * 4);
  endfunction

  // Ready sampled at the falling edge equals its value at the next rising edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ap, wp, ak, wk, bv;
    logic [1:0] br;
    ap = 1'b1;
    wp = 1'b1;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge clk_in);
      ak = awready;
      wk = wready;
      bv = bvalid;
      br = bresp;
      @(posedge clk_in);
      if (!ap && !wp && bv) begin
        bready <= 1'b0;
        chk(br, er);
        break;
      end
      if (ap && ak) begin
        awvalid <= 1'b0;
        ap = 1'b0;
      end
      if (wp && wk) begin
        wvalid <= 1'b0;
        wp = 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
    logic ap, ak, rv;
    logic [31:0] dd;
    logic [1:0] rr;
    ap = 1'b1;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge clk_in);
      ak = arready;
      rv = rvalid;
      dd = rdata;
      rr = rresp;
      @(posedge clk_in);
      if (!ap && rv) begin
        rready <= 1'b0;
        d = dd;
        chk(rr, er);
        break;
      end
      if (ap && ak) begin
        arvalid <= 1'b0;
        ap = 1'b0;
      end
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d, `CIO_RESP_OKAY);
    chk(d, exp);
  endtask

  task automatic wait_bits(input logic oe, input logic [31:0] m, input logic [31:0] e, input int mx);
    logic [31:0] v;
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < mx && !hit; n++) begin
      @(negedge clk_in);
      v = oe ? oe_n : pin_out;
      hit = ((v & m) === e);
    end
    chk(hit, 32'h1);
  endtask

  task automatic t_reset;
    @(negedge clk_in);
    chk(oe_n, 32'hffffffff);
    chk(pin_out, 32'h0);
    chk({21'h0, stb_out, evt, irq}, 32'h0);
    for (int k = 0; k < 5; k++) rdc(pa(k, `CIO_IDX_CTRL), 32'h0);
  endtask

  task automatic t_cb;
    logic [31:0] d;
    wr(`CIO_OFF_CB_BASE, 32'h0000ffff, `CIO_RESP_OKAY);
    rdc(`CIO_OFF_CB_BASE, 32'h0);
    for (int b = 2; b < 6; b++) begin
      wr(`CIO_OFF_CB_BASE + 12'(4 * b), 32'(b << 8), `CIO_RESP_OKAY);
      rdc(`CIO_OFF_CB_BASE + 12'(4 * b), 32'(b << 8));
    end
    wr(12'hffc, 32'h1, `CIO_RESP_SLVERR);
    rd(12'hffc, d, `CIO_RESP_SLVERR);
  endtask

  task automatic t_out;
    int s0, e0;
    s0 = sc;
    e0 = ec;
    wr(pa(4, `CIO_IDX_CTRL), 32'h43, `CIO_RESP_OKAY);
    wr(pa(4, `CIO_IDX_DATA), d4, `CIO_RESP_OKAY);
    repeat (12) @(negedge clk_in);
    chk(pin_out, d4);
    chk(oe_n, 32'h0);
    chk(sc - s0, 32'h1);
    chk(ec - e0, 32'h1);
    rdc(`CIO_OFF_STATUS, 32'h10);
    chk(irq, 1'b0);
    wr(`CIO_OFF_MASK, 32'h10, `CIO_RESP_OKAY);
    repeat (2) @(negedge clk_in);
    chk(irq, 1'b1);
    wr(`CIO_OFF_STATUS, 32'h10, `CIO_RESP_OKAY);
    repeat (2) @(negedge clk_in);
    chk(irq, 1'b0);
    wr(`CIO_OFF_LINK, 32'h1, `CIO_RESP_OKAY);
    repeat (2) @(negedge clk_in);
    chk(oe_n, 32'hff000000);
    wr(`CIO_OFF_LINK, 32'h0, `CIO_RESP_OKAY);
    repeat (2) @(negedge clk_in);
    chk(oe_n, 32'h0);
  endtask

  // Narrow open-drain port over the still enabled wide port
  task automatic t_od;
    wr(pa(2, `CIO_IDX_CTRL), 32'h07, `CIO_RESP_OKAY);
    wr(pa(2, `CIO_IDX_DATA), 32'h5a3c0f81, `CIO_RESP_OKAY);
    wait_bits(1'b1, 32'hff, 32'h81, 20);
    wait_bits(1'b1, 32'hff, 32'h0f, 8);
    wait_bits(1'b1, 32'hff, 32'h3c, 8);
    wait_bits(1'b1, 32'hff, 32'h5a, 8);
    chk(pin_out[31:8], d4[31:8]);
    chk(oe_n[31:8], 24'h0);
    rdc(`CIO_OFF_STATUS, 32'h04);
    wr(`CIO_OFF_STATUS, 32'h04, `CIO_RESP_OKAY);
    wr(pa(2, `CIO_IDX_CTRL), 32'h0, `CIO_RESP_OKAY);
    wr(pa(4, `CIO_IDX_CTRL), 32'h0, `CIO_RESP_OKAY);
  endtask

  task automatic t_in;
    wr(pa(1, `CIO_IDX_CTRL), 32'h21, `CIO_RESP_OKAY);
    i_cio_pin_partner.send_word(4, 1, 32'h1234abcd);
    repeat (6) @(negedge clk_in);
    chk(oe_n[3:0], 4'hf);
    rdc(pa(1, `CIO_IDX_DATA), 32'h1234abcd);
    rdc(`CIO_OFF_STATUS, 32'h02);
    wr(`CIO_OFF_STATUS, 32'h02, `CIO_RESP_OKAY);
    wr(pa(1, `CIO_IDX_CTRL), 32'h0, `CIO_RESP_OKAY);
  endtask

  // Wide port keeps the stamp single: one slice per word
  task automatic t_timed;
    logic [31:0] c1, c2;
    logic [15:0] dt, t;
    wr(pa(4, `CIO_IDX_CTRL), 32'h0b, `CIO_RESP_OKAY);
    rd(pa(4, `CIO_IDX_CNT), c1, `CIO_RESP_OKAY);
    rd(pa(4, `CIO_IDX_CNT), c2, `CIO_RESP_OKAY);
    dt = 16'(c2 - c1);
    chk(32'(dt > 16'h0 && dt < 16'h40), 32'h1);
    t = 16'(c2 + 32'd100);
    wr(pa(4, `CIO_IDX_TIME), {16'h0, t}, `CIO_RESP_OKAY);
    wr(pa(4, `CIO_IDX_DATA), 32'h1, `CIO_RESP_OKAY);
    @(negedge clk_in);
    chk(pin_out[0], 1'b0);
    wait_bits(1'b0, 32'h1, 32'h1, 200);
    rdc(pa(4, `CIO_IDX_TSTAMP), {16'h0, t});
    wr(pa(4, `CIO_IDX_CTRL), 32'h0, `CIO_RESP_OKAY);
  endtask

  task automatic t_clk;
    logic [31:0] a, b;
    wr(`CIO_OFF_CB_BASE + 12'h4, 32'h0201, `CIO_RESP_OKAY);
    wr(pa(3, `CIO_IDX_CTRL), 32'h0101, `CIO_RESP_OKAY);
    rd(pa(3, `CIO_IDX_CNT), a, `CIO_RESP_OKAY);
    i_cio_pin_partner.clock_pin0(8);
    repeat (4) @(posedge clk_in);
    rd(pa(3, `CIO_IDX_CNT), b, `CIO_RESP_OKAY);
    chk(16'(b - a), 32'h4);
  endtask

  initial begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_cb;
    t_out;
    t_od;
    t_in;
    t_timed;
    t_clk;
    tally_and_finish;
  end
endmodule
